//--- hw/amsc_pkg.sv
// Constants, register map and state encoding for the converter control block.
// Assumes a single master clock domain; pins are synchronised in the control module.
package amsc_pkg;
  localparam int ADR_W = 4;
  localparam logic [ADR_W-1:0] ADR_IDS   = 4'h0;
  localparam logic [ADR_W-1:0] ADR_CFG0  = 4'h1;
  localparam logic [ADR_W-1:0] ADR_OFS0  = 4'h2;
  localparam logic [ADR_W-1:0] ADR_GAIN0 = 4'h5;
  localparam logic [ADR_W-1:0] ADR_TRIM0 = 4'h8;
  localparam logic [ADR_W-1:0] ADR_TRIM1 = 4'h9;
  localparam int NREG = 10;

  localparam int MODE_LSB  = 6;
  localparam int RATE_LSB  = 3;
  localparam int PHASE_BIT = 2;
  localparam int FILT_LSB  = 0;
  localparam int SYNC_BIT  = 0;
  localparam int STS_SYNC_BIT = 7;
  localparam int STS_PD_BIT   = 6;

  localparam logic [7:0]  CFG0_RST       = 8'h22;
  localparam logic [7:0]  CFG0_SYNC_MASK = 8'hfc;
  localparam logic        SYNC_MODE_RST  = 1'h0;
  localparam logic [1:0]  MODE_LOW       = 2'h2;
  localparam logic [1:0]  HPF_SEL        = 2'h3;
  localparam logic [23:0] OFS_RST        = 24'h000000;
  localparam logic [23:0] GAIN_RST       = 24'h400000;
  localparam logic [15:0] TRIM_OFF       = 16'h8000;
  localparam logic [15:0] TRIM_RST       = 16'h8000;
  localparam logic [7:0]  OFS_PAD        = 8'h00;
  localparam int          GAIN_SHIFT     = 22;
  localparam logic signed [39:0] TRIM_ONE = 40'sh0008000000;
  localparam logic [31:0] SAT_HI         = 32'h7fffffff;
  localparam logic [31:0] SAT_LO         = 32'h80000000;

  localparam logic [5:0] SETTLE_PERIODS = 6'h3f;
  localparam int PER_W         = 20;
  localparam int SRC_DELAY_CYC = 8;
  localparam int CONVERSION_READY_N_HIGH_CYC = 8;
  localparam int RST_MIN_CYC   = 2;
  localparam int CMD_BITS      = 8;

  localparam logic [7:0] CMD_WAKE  = 8'h02;
  localparam logic [7:0] CMD_SLEEP = 8'h04;
  localparam logic [7:0] CMD_RESET = 8'h06;
  localparam logic [7:0] CMD_SYNC  = 8'h08;

  localparam int P_SCLK = 0;
  localparam int P_DIN  = 1;
  localparam int P_CS   = 2;
  localparam int P_SYNC = 3;
  localparam int P_POWERDOWN_PIN_N = 4;
  localparam int P_RST  = 5;
  localparam int NPIN   = 6;
  localparam logic [NPIN-1:0] PIN_IDLE = 6'h34;

  typedef enum logic [1:0] {
    ST_UNSYNC = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN    = 2'b11,
    ST_DOWN   = 2'b10
  } amsc_state_e;
endpackage : amsc_pkg

//--- hw/amsc_buf2.sv
// Two-entry buffer with registered outputs between correction and the reader.
// Assumes in_valid/in_data stable only per cycle; clr drops both entries.
module amsc_buf2 #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic         sk_v_r;
  logic [W-1:0] sk_d_r;
  wire          in_fire  = in_valid && in_ready;
  wire          out_free = !out_valid || out_ready;
  wire          sk_nxt   = sk_v_r ? !out_free : (in_fire && !out_free);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
      sk_v_r    <= 1'b0;
      sk_d_r    <= '0;
      in_ready  <= 1'b1;
    end else if (clr) begin
      out_valid <= 1'b0;
      sk_v_r    <= 1'b0;
      in_ready  <= 1'b1;
    end else begin
      // Skid slot keeps a word when the reader stalls
      if (out_free) begin
        out_valid <= sk_v_r || in_fire;
        out_data  <= sk_v_r ? sk_d_r : (in_fire ? in_data : out_data);
      end else if (in_fire) begin
        sk_d_r <= in_data;
      end
      sk_v_r   <= sk_nxt;
      in_ready <= !sk_nxt;
    end
  end
endmodule : amsc_buf2

//--- hw/amsc_ctrl.sv
// Power mode, reset, sync, rate trim and offset/gain correction control.
// Assumes the filter stage delivers one word per period on the master clock.
// Notes on behaviour
// - Two-bit mode; low power runs half speed
// - Pin low or sleep powers down; outputs hold
// - Reset command acts after eighth clock edge
// - Any reset restarts filter, restores registers
// - Sync pin rise taken on next edge
// - Sync command restarts cycle after eighth bit
// - Listed events and changes drop synchronisation
// - One bit picks pulse or continuous sync
// - Pulse sync clears filter, ready high, restart
// - Pulse sync hides next 63 ready periods
// - Continuous resync only when edge misaligned
// - Continuous sync zeroes data 63 periods
// - Trim scales period by trim over 2^27
// - 8000h disables trim; 0000h adds eight cycles
// - Both trim bytes applied together
// - Subtract offset, scale gain, saturate 32 bits
// - Offset bytes, high byte top, left aligned
// - Offset seeds highpass instead when enabled
// - Highpass on when filter select is 11b
// - Ready active low, high on sclk fall
module amsc_ctrl #(
  parameter int BASE_PERIOD = 2048
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  sclk,
  input  wire logic                  din,
  input  wire logic                  cs_n,
  input  wire logic                  sync_pin,
  input  wire logic                  powerdown_pin_n,
  input  wire logic                  reset_pin_n,
  input  wire logic                  reg_wr,
  input  wire logic [amsc_pkg::ADR_W-1:0] reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_commit,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  filt_valid,
  input  wire logic [31:0]           filt_data,
  output logic                       filt_ready,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output logic      [31:0]           out_data,
  output logic                       conversion_ready_n,
  output logic                       filt_clear,
  output logic                       hpf_seed_load,
  output logic      [31:0]           hpf_seed,
  output logic                       synced,
  output logic                       powered_down,
  output logic      [1:0]            power_mode,
  output logic                       half_clock,
  output logic      [2:0]            rate_select,
  output logic                       filter_phase,
  output logic      [1:0]            filter_select
);
  import amsc_pkg::*;
  // Pin synchronisers, three stages, change taken when stages two and three agree
  logic [NPIN-1:0] m1_r, m2_r, m3_r, pin_r;
  wire  [NPIN-1:0] pin_raw = {reset_pin_n, powerdown_pin_n, sync_pin, cs_n, din, sclk};
  wire  [NPIN-1:0] pin_nxt;
  wire  [NPIN-1:0] rise = pin_nxt & ~pin_r;
  wire  [NPIN-1:0] fall = ~pin_nxt & pin_r;
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      assign pin_nxt[g] = (m2_r[g] == m3_r[g]) ? m3_r[g] : pin_r[g];
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          m1_r[g]  <= PIN_IDLE[g];
          m2_r[g]  <= PIN_IDLE[g];
          m3_r[g]  <= PIN_IDLE[g];
          pin_r[g] <= PIN_IDLE[g];
        end else begin
          m1_r[g]  <= pin_raw[g];
          m2_r[g]  <= m1_r[g];
          m3_r[g]  <= m2_r[g];
          pin_r[g] <= pin_nxt[g];
        end
      end
    end
  endgenerate
  // Command byte capture; only the opcode byte matters here
  logic [3:0] bit_cnt_r;
  logic [6:0] shift_r;
  wire  sclk_rise = rise[P_SCLK] && !pin_r[P_CS];
  wire  cmd_done  = sclk_rise && (bit_cnt_r == 4'(CMD_BITS - 1));
  wire  [7:0] cmd_byte = {shift_r, pin_nxt[P_DIN]};
  wire  cmd_reset = cmd_done && (cmd_byte == CMD_RESET);
  wire  cmd_sync  = cmd_done && (cmd_byte == CMD_SYNC);
  wire  cmd_sleep = cmd_done && (cmd_byte == CMD_SLEEP);
  wire  cmd_wake  = cmd_done && (cmd_byte == CMD_WAKE);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bit_cnt_r <= '0;
      shift_r   <= '0;
    end else if (pin_r[P_CS]) begin
      bit_cnt_r <= '0;
    end else if (sclk_rise && bit_cnt_r != 4'(CMD_BITS)) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      shift_r   <= cmd_byte[6:0];
    end
  end
  // Reset pin: a release counts only after a long enough low time
  logic [1:0] low_cnt_r;
  wire  pin_rst = rise[P_RST] && (low_cnt_r >= 2'(RST_MIN_CYC));
  wire  srst    = pin_rst || cmd_reset;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_cnt_r <= '0;
    end else if (pin_r[P_RST]) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != 2'(RST_MIN_CYC)) begin
      low_cnt_r <= low_cnt_r + 2'h1;
    end
  end
  // User registers
  logic [7:0]  cfg0_r;
  logic        sync_mode_r;
  logic [23:0] ofs_r, gain_r;
  logic [15:0] trim_stage_r, trim_pend_r, trim_act_r;
  logic        pend_r;
  wire  wr_cfg  = reg_wr && (reg_addr == ADR_CFG0);
  wire  wr_ids  = reg_wr && (reg_addr == ADR_IDS);
  wire  cont    = sync_mode_r;
  wire  src_en  = (trim_act_r != TRIM_OFF);
  wire  [2:0] rate = cfg0_r[RATE_LSB +: 3];
  wire  [1:0] mode = cfg0_r[MODE_LSB +: 2];
  wire  hpf_en  = (cfg0_r[FILT_LSB +: 2] == HPF_SEL);
  wire  cfg_chg = wr_cfg && (((reg_wdata ^ cfg0_r) & CFG0_SYNC_MASK) != 8'h00);
  wire  ids_chg = wr_ids && (reg_wdata[SYNC_BIT] != sync_mode_r);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg0_r       <= CFG0_RST;
      sync_mode_r  <= SYNC_MODE_RST;
      ofs_r        <= OFS_RST;
      gain_r       <= GAIN_RST;
      trim_stage_r <= TRIM_RST;
      trim_pend_r  <= TRIM_RST;
    end else if (srst) begin
      cfg0_r       <= CFG0_RST;
      sync_mode_r  <= SYNC_MODE_RST;
      ofs_r        <= OFS_RST;
      gain_r       <= GAIN_RST;
      trim_stage_r <= TRIM_RST;
      trim_pend_r  <= TRIM_RST;
    end else begin
      if (wr_cfg) cfg0_r <= reg_wdata;
      if (wr_ids) sync_mode_r <= reg_wdata[SYNC_BIT];
      for (int i = 0; i < 3; i++) begin
        if (reg_wr && reg_addr == ADR_OFS0 + ADR_W'(i)) ofs_r[8*i +: 8] <= reg_wdata;
        if (reg_wr && reg_addr == ADR_GAIN0 + ADR_W'(i)) gain_r[8*i +: 8] <= reg_wdata;
      end
      if (reg_wr && reg_addr == ADR_TRIM0) trim_stage_r[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == ADR_TRIM1) trim_stage_r[15:8] <= reg_wdata;
      if (reg_commit) trim_pend_r <= trim_stage_r;
    end
  end
  // Power-down from pin or sleep command
  logic sleep_r, pd_r;
  wire  pd_nxt   = !pin_r[P_POWERDOWN_PIN_N] || sleep_r;
  wire  pd_enter = pd_nxt && !pd_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sleep_r <= 1'b0;
      pd_r    <= 1'b0;
    end else begin
      sleep_r <= srst || cmd_wake ? 1'b0 : (cmd_sleep ? 1'b1 : sleep_r);
      pd_r    <= pd_nxt;
    end
  end
  // Data period timing with half-speed tick and trim accumulator
  logic [PER_W-1:0]  cnt_r;
  logic signed [39:0] acc_r;
  logic              tick_r;
  localparam logic [PER_W-1:0] CNT_RST = (PER_W'(BASE_PERIOD) << CFG0_RST[RATE_LSB +: 3]) - PER_W'(1);
  wire  [PER_W-1:0]  per_len = PER_W'(BASE_PERIOD) << rate;
  wire  lp      = (mode == MODE_LOW);
  wire  adv     = !pd_r && (!lp || tick_r);
  wire  per_end = adv && (cnt_r == '0);
  wire  signed [36:0] step = $signed(trim_act_r) * $signed({1'b0, per_len});
  wire  signed [39:0] acc_sum = acc_r + {{3{step[36]}}, step};
  wire  ext_up  = src_en && (acc_sum >= TRIM_ONE);
  wire  ext_dn  = src_en && (acc_sum <= -TRIM_ONE);
  wire  signed [39:0] acc_nxt = ext_up ? acc_sum - TRIM_ONE : (ext_dn ? acc_sum + TRIM_ONE : acc_sum);
  wire  [PER_W-1:0] reload = per_len - PER_W'(1) + PER_W'(ext_up) - PER_W'(ext_dn);
  wire  [PER_W-1:0] sync_load = per_len - PER_W'(1) + (src_en ? PER_W'(SRC_DELAY_CYC) : PER_W'(0));
  wire  src_chg = per_end && pend_r && !reg_commit && ((trim_pend_r != TRIM_OFF) != src_en);
  // Synchronisation state
  amsc_state_e state_r, state_nxt;
  logic [5:0]  settle_r;
  wire  sync_evt = (rise[P_SYNC] || cmd_sync) && !pd_r;
  wire  unsynced = (state_r == ST_UNSYNC);
  wire  do_sync  = sync_evt && !srst && (!cont || unsynced || cnt_r != '0);
  wire  lose     = cfg_chg || ids_chg || src_chg || pd_enter;
  wire  settling = (state_r == ST_SETTLE) && (settle_r != 6'h00);
  wire  pulse_supp = settling && !cont;
  wire  zero_data  = settling && cont;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_DOWN:   state_nxt = pd_r ? ST_DOWN : ST_UNSYNC;
      ST_SETTLE: state_nxt = (per_end && settle_r == 6'h01) ? ST_RUN : ST_SETTLE;
      default:   state_nxt = state_r;
    endcase
    if (do_sync) state_nxt = ST_SETTLE;
    if (lose) state_nxt = ST_UNSYNC;
    if (pd_r) state_nxt = ST_DOWN;
    if (srst) state_nxt = ST_UNSYNC;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r    <= ST_UNSYNC;
      settle_r   <= '0;
      cnt_r      <= CNT_RST; // No ready strobe straight out of reset
      acc_r      <= '0;
      tick_r     <= 1'b0;
      trim_act_r <= TRIM_RST;
      pend_r     <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tick_r  <= !tick_r;
      if (srst) begin
        trim_act_r <= TRIM_RST;
        pend_r     <= 1'b0;
      end else if (reg_commit) begin
        pend_r <= 1'b1;
      end else if (per_end && pend_r) begin
        trim_act_r <= trim_pend_r;
        pend_r     <= 1'b0;
      end
      if (srst || do_sync) begin
        cnt_r    <= sync_load;
        acc_r    <= '0;
        settle_r <= srst ? 6'h00 : SETTLE_PERIODS;
      end else if (per_end) begin
        cnt_r    <= reload;
        acc_r    <= src_en ? acc_nxt : 40'sh0;
        settle_r <= (settle_r != 6'h00) ? settle_r - 6'h01 : settle_r;
      end else if (adv) begin
        cnt_r <= cnt_r - PER_W'(1);
      end
    end
  end

  // Ready strobe; held static while powered down, except that a reset forces it high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conversion_ready_n <= 1'b1;
    end else if (srst || (do_sync && !cont)) begin
      conversion_ready_n <= 1'b1;
    end else if (pd_r) begin
      conversion_ready_n <= conversion_ready_n;
    end else if (fall[P_SCLK] || (adv && cnt_r == PER_W'(CONVERSION_READY_N_HIGH_CYC))) begin
      conversion_ready_n <= 1'b1;
    end else if (per_end && !pulse_supp) begin
      conversion_ready_n <= 1'b0;
    end
  end

  // Correction datapath
  wire  [31:0] ofs_al = {ofs_r, OFS_PAD};
  wire  signed [32:0] diff = hpf_en ? $signed({filt_data[31], filt_data})
                                    : $signed({filt_data[31], filt_data}) - $signed({ofs_al[31], ofs_al});
  wire  signed [57:0] prod = diff * $signed({1'b0, gain_r});
  wire  signed [57:0] scl  = prod >>> GAIN_SHIFT;
  wire  ovf_hi = !scl[57] && (|scl[56:31]);
  wire  ovf_lo = scl[57] && !(&scl[56:31]);
  wire  [31:0] corr = ovf_hi ? SAT_HI : (ovf_lo ? SAT_LO : scl[31:0]);
  wire  buf_in_valid = filt_valid && !pd_r && !pulse_supp;
  wire  [31:0] buf_in_data = zero_data ? 32'h00000000 : corr;

  amsc_buf2 #(
    .W (32)
  ) u_buf (
    .clk       (ref_clk),
    .rst       (rst),
    .clr       (srst),
    .in_valid  (buf_in_valid),
    .in_ready  (filt_ready),
    .in_data   (buf_in_data),
    .out_valid (out_valid),
    .out_ready (out_ready && !pd_r),
    .out_data  (out_data)
  );

  // Highpass seed and status outputs
  logic hpf_en_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hpf_en_r      <= 1'b0;
      half_clock    <= 1'b0;
      hpf_seed_load <= 1'b0;
      hpf_seed      <= '0;
      filt_clear    <= 1'b0;
      synced        <= 1'b0;
      powered_down  <= 1'b0;
    end else begin
      hpf_en_r      <= hpf_en;
      hpf_seed_load <= hpf_en && !hpf_en_r;
      if (hpf_en && !hpf_en_r) hpf_seed <= ofs_al;
      filt_clear    <= srst || do_sync;
      synced        <= state_nxt[0];
      powered_down  <= pd_r;
      half_clock    <= lp;
    end
  end

  assign power_mode    = mode;
  assign rate_select   = rate;
  assign filter_phase  = cfg0_r[PHASE_BIT];
  assign filter_select = cfg0_r[FILT_LSB +: 2];
  // Register readback, registered to keep outputs on flops
  wire  [7:0] ids_rd = {synced, powered_down, 5'h00, sync_mode_r};
  wire  [8*NREG-1:0] rd_flat = {trim_act_r, gain_r, ofs_r, cfg0_r, ids_rd};
  wire  [7:0] rd_mux = (int'(reg_addr) < NREG) ? rd_flat[8*reg_addr +: 8] : 8'h00;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) reg_rdata <= '0;
    else reg_rdata <= rd_mux;
  end

  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_PULSE_SYNC: assert property (do_sync && !cont |=> filt_clear && conversion_ready_n
                                   && settle_r == SETTLE_PERIODS) else $error("pulse sync effects missing");
  AST_PULSE_HIDE: assert property (pulse_supp |-> conversion_ready_n)
    else $error("ready asserted during settling");
  AST_CONT_SYNC: assert property (do_sync && cont |=> state_r == ST_SETTLE && filt_clear)
    else $error("continuous sync not taken");
  AST_CONT_ALIGN: assert property (sync_evt && cont && !unsynced && cnt_r == '0 && !srst
                                   |=> !filt_clear) else $error("aligned edge resynchronised");
  AST_CMD_RESET: assert property (cmd_reset |=> state_r == ST_UNSYNC && filt_clear
                                  && cfg0_r == CFG0_RST && gain_r == GAIN_RST) else $error("reset command ignored");
  AST_LOSE_CFG: assert property (cfg_chg && !srst && !pd_r |=> state_r == ST_UNSYNC)
    else $error("config change kept sync");
  AST_PD_HOLD: assert property (pd_r && $past(pd_r) && !$past(srst) |-> $stable(conversion_ready_n))
    else $error("ready moved while powered down");
  AST_SRC_DELAY: assert property (do_sync && src_en && !wr_cfg
                                  |=> cnt_r == $past(per_len) + PER_W'(SRC_DELAY_CYC - 1)) else $error("trim delay wrong");
  AST_TRIM_PAIR: assert property ($changed(trim_act_r) |-> $past(per_end) || $past(srst))
    else $error("trim applied off boundary");
  AST_GAIN_UNITY: assert property (buf_in_valid && !zero_data && hpf_en && gain_r == GAIN_RST
                                   |-> buf_in_data == filt_data) else $error("unity gain altered data");
  AST_HPF_SEED: assert property ($rose(hpf_en) |=> hpf_seed_load && hpf_seed == $past(ofs_al))
    else $error("highpass seed not loaded");
  AST_SCLK_FALL: assert property (fall[P_SCLK] && !pd_r |=> conversion_ready_n)
    else $error("ready not released on sclk fall");

  CV_PULSE: cover property (do_sync && !cont);
  CV_RESYNC: cover property (do_sync && cont && !unsynced);
  CV_RUN: cover property (state_r == ST_SETTLE ##1 state_r == ST_RUN);
  CV_PD: cover property (pd_enter);
endmodule : amsc_ctrl

//--- testbench/amsc_host.sv
// Host model: serial commands and the sync, power-down and reset pins.
// Assumes the bench calls its tasks; sclk stands low outside frames.
module amsc_host (
  input  wire logic ref_clk,
  output logic      sclk,
  output logic      din,
  output logic      cs_n,
  output logic      sync_pin,
  output logic      powerdown_pin_n,
  output logic      reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {sclk, din, cs_n, sync_pin, powerdown_pin_n, reset_pin_n} = 6'h1b;
  end
  task automatic send(input logic [7:0] op);
    cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      din = op[i];
      #200 sclk = 1'b1;
      #200 sclk = 1'b0;
    end
    // Released line shows the inverse, not a stale bit
    din = ~din;
    #200 cs_n = 1'b1;
  endtask : send
  task automatic sync_rise();
    @(negedge ref_clk) sync_pin = 1'b1;
    repeat (4) @(negedge ref_clk);
    sync_pin = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : sync_rise
  task automatic pd(input logic v);
    @(negedge ref_clk) powerdown_pin_n = v;
    @(posedge ref_clk);
    #1;
  endtask : pd
  task automatic pin_reset();
    reset_pin_n = 1'b0;
    #150 reset_pin_n = 1'b1;
  endtask : pin_reset
endmodule : amsc_host

//--- testbench/amsc_ctrl_tb.sv
// Bench for amsc_ctrl: registers, commands, pins, sync and the stream.
// Assumes BASE_PERIOD 16, so a period at rate 0 is 16 cycles.
module amsc_ctrl_tb;
  import amsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BP = 16;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, din, cs_n, sync_pin, powerdown_pin_n, reset_pin_n;
  logic reg_wr = 1'b0, reg_commit = 1'b0, filt_valid = 1'b0, out_ready = 1'b0;
  logic [ADR_W-1:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h0, reg_rdata;
  logic [31:0] filt_data = 32'h0, out_data, hpf_seed;
  logic filt_ready, out_valid, conversion_ready_n, filt_clear, hpf_seed_load;
  logic synced, powered_down, half_clock, filter_phase;
  logic [1:0] power_mode, filter_select;
  logic [2:0] rate_select;
  int n_fail = 0, num_checks = 0, n, lo;
  logic [23:0] ofs[3] = '{24'h000100, 24'h800000, 24'h7fffff};
  logic [23:0] gn[3]  = '{24'h200000, 24'h400000, 24'h400000};
  logic [31:0] dat[3] = '{32'h00030000, 32'h7fffffff, 32'h80000000};
  always #25 ref_clk = ~ref_clk;
  amsc_host u_host (.*);
  amsc_ctrl #(.BASE_PERIOD(BP)) u_dut (.*);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    reg_addr = a;
    cyc(2);
    chk("reg_rdata", {24'h0, e}, {24'h0, reg_rdata});
  endtask : rd
  // Floor shift; cases chosen with no remainder so rounding cannot matter
  function automatic logic [31:0] corr(input logic [31:0] d, input logic [23:0] o, input logic [23:0] g);
    longint v;
    v = ((longint'($signed(d)) - longint'($signed({o, 8'h00}))) * longint'({40'h0, g})) >>> 22;
    if (v > 64'sh7fffffff) return 32'h7fffffff;
    if (v < -64'sh80000000) return 32'h80000000;
    return v[31:0];
  endfunction : corr
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #1_000_000;
    n_fail++;
    end_of_test();
  end
  initial begin
    cyc(2);
    rst = 1'b0;
    cyc(4);
    chk("rate_select", 32'h4, rate_select);
    chk("filter_select", 32'h2, filter_select);
    chk("ready_n", 32'h1, conversion_ready_n);
    rd(ADR_CFG0, CFG0_RST);
    rd(ADR_TRIM1, 8'h80);
    rd(4'hc, 8'h00);
    wr(ADR_CFG0, 8'h82);
    cyc(1);
    chk("power_mode", 32'h2, power_mode);
    chk("half_clock", 32'h1, half_clock);
    wr(ADR_CFG0, 8'h02);
    for (int c = 0; c < 3; c++) begin
      for (int i = 0; i < 3; i++) begin
        wr(4'(ADR_OFS0 + i), ofs[c][8*i+:8]);
        wr(4'(ADR_GAIN0 + i), gn[c][8*i+:8]);
      end
      filt_data = dat[c];
      filt_valid = 1'b1;
      cyc(1);
      filt_valid = 1'b0;
      for (int i = 0; i < 8 && out_valid !== 1'b1; i++) cyc(1);
      chk("out_data", corr(dat[c], ofs[c], gn[c]), out_data);
      out_ready = 1'b1;
      cyc(1);
      out_ready = 1'b0;
    end
    wr(ADR_CFG0, 8'h03);
    for (int i = 0; i < 8 && hpf_seed_load !== 1'b1; i++) cyc(1);
    chk("hpf_seed", 32'h7fffff00, hpf_seed);
    filt_data = 32'h12345600;
    filt_valid = 1'b1;
    cyc(1);
    filt_valid = 1'b0;
    for (int i = 0; i < 8 && out_valid !== 1'b1; i++) cyc(1);
    chk("hpf_bypass", 32'h12345600, out_data);
    out_ready = 1'b1;
    cyc(1);
    out_ready = 1'b0;
    wr(ADR_CFG0, 8'h02);
    u_host.sync_rise();
    chk("synced", 32'h1, synced);
    lo = 0;
    repeat (62 * BP) begin
      cyc(1);
      lo += (conversion_ready_n === 1'b0);
    end
    chk("hidden_ready", 32'h0, lo);
    for (int i = 0; i < 4 * BP && conversion_ready_n !== 1'b0; i++) cyc(1);
    chk("ready_n", 32'h0, conversion_ready_n);
    wr(ADR_CFG0, 8'h0a);
    cyc(2);
    chk("synced", 32'h0, synced);
    u_host.send(CMD_SYNC);
    chk("synced", 32'h1, synced);
    wr(ADR_IDS, 8'h01);
    cyc(2);
    chk("synced", 32'h0, synced);
    u_host.sync_rise();
    filt_data = 32'h00050000;
    filt_valid = 1'b1;
    cyc(1);
    filt_valid = 1'b0;
    for (int i = 0; i < 8 && out_valid !== 1'b1; i++) cyc(1);
    chk("zeroed", 32'h0, out_data);
    out_ready = 1'b1;
    for (int i = 0; i < 4 * BP && conversion_ready_n !== 1'b0; i++) cyc(1);
    chk("ready_n", 32'h0, conversion_ready_n);
    u_host.pd(1'b0);
    cyc(6);
    chk("powered_down", 32'h1, powered_down);
    chk("synced", 32'h0, synced);
    u_host.pd(1'b1);
    cyc(6);
    chk("powered_down", 32'h0, powered_down);
    u_host.send(CMD_SLEEP);
    cyc(2);
    chk("powered_down", 32'h1, powered_down);
    u_host.send(CMD_WAKE);
    cyc(2);
    chk("powered_down", 32'h0, powered_down);
    u_host.send(CMD_RESET);
    cyc(2);
    rd(ADR_CFG0, CFG0_RST);
    rd(4'(ADR_GAIN0 + 2), 8'h40);
    rd(4'(ADR_OFS0 + 2), 8'h00);
    wr(ADR_CFG0, 8'h0e);
    chk("filter_phase", 32'h1, filter_phase);
    u_host.pin_reset();
    cyc(8);
    rd(ADR_CFG0, CFG0_RST);
    wr(ADR_TRIM0, 8'h00);
    wr(ADR_TRIM1, 8'h00);
    rd(ADR_TRIM1, 8'h80);
    reg_commit = 1'b1;
    cyc(1);
    reg_commit = 1'b0;
    cyc(6 * BP << 4);
    rd(ADR_TRIM1, 8'h00);
    out_ready = 1'b0;
    n = 0;
    while (filt_ready === 1'b1 && n < 8) begin
      filt_data = 32'h100 * (n + 1);
      filt_valid = 1'b1;
      cyc(1);
      n++;
    end
    filt_valid = 1'b0;
    chk("fill_depth", 32'h1, 32'(n >= 2));
    out_ready = 1'b1;
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 8 && out_valid !== 1'b1; i++) cyc(1);
      chk("drain", 32'h100 * (k + 1), out_data);
      cyc(1);
    end
    chk("empty", 32'h0, out_valid);
    u_host.send(CMD_SYNC);
    chk("synced", 32'h1, synced);
    end_of_test();
  end
endmodule : amsc_ctrl_tb
